// file: core/rpc_pkg.sv
package rpc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [11:0] OFS_POSTED = 12'h1a5;
  localparam logic [11:0] OFS_NPOSTED = 12'h1a6;
  localparam logic [11:0] OFS_PERF_ONE = 12'h1a7;
  localparam logic [11:0] OFS_CPL_TMO = 12'h1a8;
  localparam logic [11:0] OFS_CRS = 12'h1a9;
  localparam logic [11:0] OFS_PERF_TWO = 12'h1aa;

  // ****************************************
  // Reset values and writable-bit masks
  // ****************************************
  localparam logic [7:0] RST_POSTED_WIDE = 8'hff;
  localparam logic [7:0] RST_POSTED_NARROW = 8'h73;
  localparam logic [7:0] RST_NPOSTED_WIDE = 8'h1f;
  localparam logic [7:0] RST_NPOSTED_NARROW = 8'h13;
  localparam logic [7:0] RST_PERF_ONE = 8'hc4;
  localparam logic [7:0] RST_CPL_TMO = 8'h10;
  localparam logic [7:0] RST_CRS = 8'h00;
  localparam logic [7:0] RST_PERF_TWO = 8'h16;
  localparam logic [7:0] WM_ALL = 8'hff;
  localparam logic [7:0] WM_POSTED_NARROW = 8'h73;
  localparam logic [7:0] WM_NPOSTED_NARROW = 8'hf3;
  localparam logic [7:0] WM_PERF_ONE = 8'hfd;
  localparam logic [7:0] WM_PERF_TWO = 8'h1f;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned POS_NPH_INF = 7;
  localparam int unsigned POS_RD_REL = 4;
  localparam int unsigned POS_WAIT_WR = 3;
  localparam int unsigned POS_ORDER = 2;
  localparam int unsigned POS_TMO_METHOD = 7;
  localparam int unsigned POS_CFG_TMO = 4;
  localparam int unsigned POS_CRS_DLY = 0;
  localparam int unsigned POS_CRS_EN = 0;
  localparam int unsigned POS_UPDFC_P = 4;
  localparam int unsigned POS_MERGE_THR = 2;
  localparam int unsigned POS_MERGE_EN = 1;
  localparam int unsigned POS_RD_TIMING = 0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned CFG_TMO0_MS = 100;
  localparam int unsigned CFG_TMO1_MS = 500;
  localparam int unsigned CFG_TMO2_MS = 1000;
  localparam int unsigned CFG_TMO3_MS = 1500;
  localparam int unsigned CFG_TMO0_CYC = CFG_TMO0_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned CFG_TMO1_CYC = CFG_TMO1_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned CFG_TMO2_CYC = CFG_TMO2_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned CFG_TMO3_CYC = CFG_TMO3_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [4:0] CRS_DLY0_CYC = 5'h01;
  localparam logic [4:0] CRS_DLY1_CYC = 5'h04;
  localparam logic [4:0] CRS_DLY2_CYC = 5'h08;
  localparam logic [4:0] CRS_DLY3_CYC = 5'h10;

  typedef enum logic [1:0] {
    TMR_IDLE = 2'b00,
    TMR_WAIT = 2'b01,
    TMR_DELAY = 2'b10
  } rpc_tmr_state_t;

endpackage

// file: core/rpc_tmr_if.sv
`timescale 1ns/1ns
interface rpc_tmr_if;
  logic start;
  logic done;
  logic crs;
  logic [1:0] tmo_sel;
  logic [1:0] dly_sel;
  logic retry_en;
  logic policy;
  logic tmo;
  logic reissue;
  logic all_ones;

  modport ctrl (output start, done, crs, tmo_sel, dly_sel, retry_en, policy,
                input tmo, reissue, all_ones);
  modport tmr (input start, done, crs, tmo_sel, dly_sel, retry_en, policy,
               output tmo, reissue, all_ones);
endinterface

// file: core/rpc_cfg_timer.sv
`timescale 1ns/1ns
module rpc_cfg_timer #(
  parameter int unsigned TMO0_CYC = rpc_pkg::CFG_TMO0_CYC,
  parameter int unsigned TMO1_CYC = rpc_pkg::CFG_TMO1_CYC,
  parameter int unsigned TMO2_CYC = rpc_pkg::CFG_TMO2_CYC,
  parameter int unsigned TMO3_CYC = rpc_pkg::CFG_TMO3_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  rpc_tmr_if.tmr t
);

  rpc_pkg::rpc_tmr_state_t state_q, state_d;
  logic [26:0] cnt_q, cnt_d;
  logic tmo_q, tmo_d;
  logic reissue_q, reissue_d;
  logic ones_q, ones_d;
  logic [4:0] dly;
  logic [26:0] tmo_load;

  always_comb begin
    unique case (t.tmo_sel)
      2'b00: tmo_load = 27'(TMO0_CYC - 1);
      2'b01: tmo_load = 27'(TMO1_CYC - 1);
      2'b10: tmo_load = 27'(TMO2_CYC - 1);
      2'b11: tmo_load = 27'(TMO3_CYC - 1);
    endcase
    unique case (t.dly_sel)
      2'b00: dly = rpc_pkg::CRS_DLY0_CYC;
      2'b01: dly = rpc_pkg::CRS_DLY1_CYC;
      2'b10: dly = rpc_pkg::CRS_DLY2_CYC;
      2'b11: dly = rpc_pkg::CRS_DLY3_CYC;
    endcase
  end

  // A retry-status answer while retry is off ends the request with all ones.
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    tmo_d = 1'b0;
    reissue_d = 1'b0;
    ones_d = 1'b0;
    unique case (state_q)
      rpc_pkg::TMR_IDLE: begin
        if (t.start) begin
          state_d = rpc_pkg::TMR_WAIT;
          cnt_d = tmo_load;
        end
      end
      rpc_pkg::TMR_WAIT: begin
        if (t.done) begin
          state_d = rpc_pkg::TMR_IDLE;
        end else if (t.crs) begin
          if (t.retry_en && t.policy) begin
            if (dly == 5'h01) begin
              reissue_d = 1'b1;
              cnt_d = tmo_load;
            end else begin
              state_d = rpc_pkg::TMR_DELAY;
              cnt_d = {22'h0, dly - 5'h02};
            end
          end else begin
            state_d = rpc_pkg::TMR_IDLE;
            ones_d = 1'b1;
          end
        end else if (cnt_q == 27'h0) begin
          state_d = rpc_pkg::TMR_IDLE;
          tmo_d = 1'b1;
        end else begin
          cnt_d = cnt_q - 27'h1;
        end
      end
      rpc_pkg::TMR_DELAY: begin
        if (cnt_q == 27'h0) begin
          state_d = rpc_pkg::TMR_WAIT;
          reissue_d = 1'b1;
          cnt_d = tmo_load;
        end else begin
          cnt_d = cnt_q - 27'h1;
        end
      end
      default: begin
        state_d = rpc_pkg::TMR_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_q <= rpc_pkg::TMR_IDLE;
      cnt_q <= 27'h0;
      tmo_q <= 1'b0;
      reissue_q <= 1'b0;
      ones_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      tmo_q <= tmo_d;
      reissue_q <= reissue_d;
      ones_q <= ones_d;
    end
  end

  assign t.tmo = tmo_q;
  assign t.reissue = reissue_q;
  assign t.all_ones = ones_q;

endmodule

// file: core/rpc_ctrl.sv
`timescale 1ns/1ns
module rpc_ctrl #(
  parameter bit WIDE_PORT = 1'b1,
  parameter int unsigned CFG_TMO0_CYC = rpc_pkg::CFG_TMO0_CYC,
  parameter int unsigned CFG_TMO1_CYC = rpc_pkg::CFG_TMO1_CYC,
  parameter int unsigned CFG_TMO2_CYC = rpc_pkg::CFG_TMO2_CYC,
  parameter int unsigned CFG_TMO3_CYC = rpc_pkg::CFG_TMO3_CYC
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Configuration access
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [11:0] cfg_addr_i,
  input wire logic [7:0] cfg_wdata_i,
  output logic [7:0] cfg_rdata_o,
  // Initial credits
  input wire logic fc_init_start_i,
  output logic [4:0] pd_lines_o,
  output logic [7:0] pd_credit_o,
  output logic [5:0] ph_levels_o,
  output logic [7:0] ph_credit_o,
  output logic [5:0] nph_levels_o,
  output logic [7:0] nph_credit_o,
  output logic nph_infinite_o,
  // Credit updates
  input wire logic pd_upd_req_i,
  input wire logic ph_upd_req_i,
  input wire logic nph_upd_req_i,
  output logic updatefc_p_o,
  output logic updatefc_np_o,
  // Upstream ordering and read path
  input wire logic rd_first_word_i,
  input wire logic rd_last_word_i,
  input wire logic up_wr_pending_i,
  output logic rd_fifo_release_o,
  output logic dn_rd_hold_o,
  output logic up_wr_bypass_o,
  output logic slow_rd_timing_o,
  // Completion timeout
  input wire logic phy_retrain_i,
  output logic cpl_tmo_restart_o,
  // Configuration requests
  input wire logic cfg_req_start_i,
  input wire logic cfg_cpl_i,
  input wire logic crs_cpl_i,
  input wire logic separate_retry_policy_bit_i,
  output logic cfg_tmo_o,
  output logic cfg_reissue_o,
  output logic cfg_all_ones_o,
  // Completion merging
  input wire logic [5:0] retry_hdr_cnt_i,
  input wire logic port_to_core_cpl_ready_i,
  output logic cpl_emit_o,
  output logic cpl_merge_o
);

  // ****************************************
  // Port-type constants
  // ****************************************
  localparam logic [7:0] POSTED_RST =
    WIDE_PORT ? rpc_pkg::RST_POSTED_WIDE : rpc_pkg::RST_POSTED_NARROW;
  localparam logic [7:0] NPOSTED_RST =
    WIDE_PORT ? rpc_pkg::RST_NPOSTED_WIDE : rpc_pkg::RST_NPOSTED_NARROW;
  localparam logic [7:0] POSTED_WM =
    WIDE_PORT ? rpc_pkg::WM_ALL : rpc_pkg::WM_POSTED_NARROW;
  localparam logic [7:0] NPOSTED_WM =
    WIDE_PORT ? rpc_pkg::WM_ALL : rpc_pkg::WM_NPOSTED_NARROW;

  // ****************************************
  // Decode functions
  // ****************************************
  function automatic logic [7:0] merge_bits(input logic [7:0] old_v, input logic [7:0] new_v,
                                            input logic [7:0] mask);
    merge_bits = (old_v & ~mask) | (new_v & mask);
  endfunction

  function automatic logic [7:0] hdr_credit(input logic [3:0] code);
    if (WIDE_PORT) begin
      hdr_credit = {3'h0, code, 1'b0} + 8'h02;
    end else begin
      hdr_credit = 8'h01 << code[1:0];
    end
  endfunction

  function automatic logic [5:0] hdr_levels(input logic [3:0] code);
    if (WIDE_PORT && code > 4'h2) begin
      hdr_levels = {1'b0, code, 1'b0} + 6'h02;
    end else begin
      hdr_levels = 6'h01 << code[1:0];
    end
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] posted_q, posted_d;
  logic [7:0] nposted_q, nposted_d;
  logic [7:0] perf_one_q, perf_one_d;
  logic [7:0] cpl_tmo_q, cpl_tmo_d;
  logic [7:0] crs_q, crs_d;
  logic [7:0] perf_two_q, perf_two_d;
  logic [7:0] rdata_q, rdata_d;

  // Narrow ports keep their read-only bits, so reserved codes are unreachable.
  always_comb begin
    posted_d = posted_q;
    nposted_d = nposted_q;
    perf_one_d = perf_one_q;
    cpl_tmo_d = cpl_tmo_q;
    crs_d = crs_q;
    perf_two_d = perf_two_q;
    rdata_d = rdata_q;
    if (cfg_wr_i) begin
      unique case (cfg_addr_i)
        rpc_pkg::OFS_POSTED: posted_d = merge_bits(posted_q, cfg_wdata_i, POSTED_WM);
        rpc_pkg::OFS_NPOSTED: nposted_d = merge_bits(nposted_q, cfg_wdata_i, NPOSTED_WM);
        rpc_pkg::OFS_PERF_ONE: perf_one_d = merge_bits(perf_one_q, cfg_wdata_i, rpc_pkg::WM_PERF_ONE);
        rpc_pkg::OFS_CPL_TMO: cpl_tmo_d = cfg_wdata_i;
        rpc_pkg::OFS_CRS: crs_d = cfg_wdata_i;
        rpc_pkg::OFS_PERF_TWO: perf_two_d = merge_bits(perf_two_q, cfg_wdata_i, rpc_pkg::WM_PERF_TWO);
        default: ;
      endcase
    end
    if (cfg_rd_i) begin
      unique case (cfg_addr_i)
        rpc_pkg::OFS_POSTED: rdata_d = posted_q;
        rpc_pkg::OFS_NPOSTED: rdata_d = nposted_q;
        rpc_pkg::OFS_PERF_ONE: rdata_d = perf_one_q;
        rpc_pkg::OFS_CPL_TMO: rdata_d = cpl_tmo_q;
        rpc_pkg::OFS_CRS: rdata_d = crs_q;
        rpc_pkg::OFS_PERF_TWO: rdata_d = perf_two_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      posted_q <= POSTED_RST;
      nposted_q <= NPOSTED_RST;
      perf_one_q <= rpc_pkg::RST_PERF_ONE;
      cpl_tmo_q <= rpc_pkg::RST_CPL_TMO;
      crs_q <= rpc_pkg::RST_CRS;
      perf_two_q <= rpc_pkg::RST_PERF_TWO;
      rdata_q <= 8'h00;
    end else begin
      posted_q <= posted_d;
      nposted_q <= nposted_d;
      perf_one_q <= perf_one_d;
      cpl_tmo_q <= cpl_tmo_d;
      crs_q <= crs_d;
      perf_two_q <= perf_two_d;
      rdata_q <= rdata_d;
    end
  end

  // ****************************************
  // Initial credit capture
  // ****************************************
  logic [4:0] pd_lines_q, pd_lines_d;
  logic [7:0] pd_credit_q, pd_credit_d;
  logic [5:0] ph_levels_q, ph_levels_d;
  logic [7:0] ph_credit_q, ph_credit_d;
  logic [5:0] nph_levels_q, nph_levels_d;
  logic [7:0] nph_credit_q, nph_credit_d;
  logic nph_inf_q, nph_inf_d;

  // Capturing only at initialisation keeps the link's view stable; later
  // writes take effect at the next initialisation.
  always_comb begin
    pd_lines_d = pd_lines_q;
    pd_credit_d = pd_credit_q;
    ph_levels_d = ph_levels_q;
    ph_credit_d = ph_credit_q;
    nph_levels_d = nph_levels_q;
    nph_credit_d = nph_credit_q;
    nph_inf_d = nph_inf_q;
    if (fc_init_start_i) begin
      pd_lines_d = {1'b0, posted_q[7:4]} + 5'h01;
      pd_credit_d = {2'h0, posted_q[7:4], 2'h0} + 8'h04;
      ph_levels_d = hdr_levels(posted_q[3:0]);
      ph_credit_d = hdr_credit(posted_q[3:0]);
      nph_levels_d = hdr_levels(nposted_q[3:0]);
      nph_credit_d = hdr_credit(nposted_q[3:0]);
      nph_inf_d = nposted_q[rpc_pkg::POS_NPH_INF];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pd_lines_q <= 5'h00;
      pd_credit_q <= 8'h00;
      ph_levels_q <= 6'h00;
      ph_credit_q <= 8'h00;
      nph_levels_q <= 6'h00;
      nph_credit_q <= 8'h00;
      nph_inf_q <= 1'b0;
    end else begin
      pd_lines_q <= pd_lines_d;
      pd_credit_q <= pd_credit_d;
      ph_levels_q <= ph_levels_d;
      ph_credit_q <= ph_credit_d;
      nph_levels_q <= nph_levels_d;
      nph_credit_q <= nph_credit_d;
      nph_inf_q <= nph_inf_d;
    end
  end

  // ****************************************
  // Upstream controls and completion merge
  // ****************************************
  logic updp_q, updp_d;
  logic updnp_q, updnp_d;
  logic release_q, release_d;
  logic hold_q, hold_d;
  logic bypass_q, bypass_d;
  logic slow_q, slow_d;
  logic restart_q, restart_d;
  logic emit_q, emit_d;
  logic mrg_q, mrg_d;
  logic parked_q, parked_d;
  logic merge_on;

  always_comb begin
    updp_d = pd_upd_req_i || (perf_two_q[rpc_pkg::POS_UPDFC_P] && ph_upd_req_i);
    updnp_d = nph_upd_req_i && !nph_inf_q;
    release_d = perf_one_q[rpc_pkg::POS_RD_REL] ? rd_first_word_i : rd_last_word_i;
    hold_d = perf_one_q[rpc_pkg::POS_WAIT_WR] && up_wr_pending_i;
    bypass_d = perf_one_q[rpc_pkg::POS_ORDER];
    slow_d = perf_two_q[rpc_pkg::POS_RD_TIMING];
    restart_d = phy_retrain_i && cpl_tmo_q[rpc_pkg::POS_TMO_METHOD];
    merge_on = perf_two_q[rpc_pkg::POS_MERGE_EN] &&
               (retry_hdr_cnt_i >= {2'h0, perf_two_q[rpc_pkg::POS_MERGE_THR +: 2]} + 6'h01);
    emit_d = 1'b0;
    mrg_d = 1'b0;
    parked_d = parked_q;
    // A parked first completion waits for a second one while merging qualifies, and
    // leaves alone once merging stops qualifying, at the cost of one lost merge chance.
    if (parked_q) begin
      if (port_to_core_cpl_ready_i) begin
        mrg_d = 1'b1;
        parked_d = 1'b0;
      end else if (!merge_on) begin
        emit_d = 1'b1;
        parked_d = 1'b0;
      end
    end else if (port_to_core_cpl_ready_i) begin
      if (merge_on) begin
        parked_d = 1'b1;
      end else begin
        emit_d = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      updp_q <= 1'b0;
      updnp_q <= 1'b0;
      release_q <= 1'b0;
      hold_q <= 1'b0;
      bypass_q <= 1'b1;
      slow_q <= 1'b0;
      restart_q <= 1'b0;
      emit_q <= 1'b0;
      mrg_q <= 1'b0;
      parked_q <= 1'b0;
    end else begin
      updp_q <= updp_d;
      updnp_q <= updnp_d;
      release_q <= release_d;
      hold_q <= hold_d;
      bypass_q <= bypass_d;
      slow_q <= slow_d;
      restart_q <= restart_d;
      emit_q <= emit_d;
      mrg_q <= mrg_d;
      parked_q <= parked_d;
    end
  end

  // ****************************************
  // Configuration request timer
  // ****************************************
  rpc_tmr_if tmr_bus ();

  assign tmr_bus.start = cfg_req_start_i;
  assign tmr_bus.done = cfg_cpl_i;
  assign tmr_bus.crs = crs_cpl_i;
  assign tmr_bus.tmo_sel = cpl_tmo_q[rpc_pkg::POS_CFG_TMO +: 2];
  assign tmr_bus.dly_sel = cpl_tmo_q[rpc_pkg::POS_CRS_DLY +: 2];
  assign tmr_bus.retry_en = crs_q[rpc_pkg::POS_CRS_EN];
  assign tmr_bus.policy = separate_retry_policy_bit_i;

  rpc_cfg_timer #(
    .TMO0_CYC(CFG_TMO0_CYC),
    .TMO1_CYC(CFG_TMO1_CYC),
    .TMO2_CYC(CFG_TMO2_CYC),
    .TMO3_CYC(CFG_TMO3_CYC)
  ) u_timer (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .t(tmr_bus.tmr)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign cfg_rdata_o = rdata_q;
  assign pd_lines_o = pd_lines_q;
  assign pd_credit_o = pd_credit_q;
  assign ph_levels_o = ph_levels_q;
  assign ph_credit_o = ph_credit_q;
  assign nph_levels_o = nph_levels_q;
  assign nph_credit_o = nph_credit_q;
  assign nph_infinite_o = nph_inf_q;
  assign updatefc_p_o = updp_q;
  assign updatefc_np_o = updnp_q;
  assign rd_fifo_release_o = release_q;
  assign dn_rd_hold_o = hold_q;
  assign up_wr_bypass_o = bypass_q;
  assign slow_rd_timing_o = slow_q;
  assign cpl_tmo_restart_o = restart_q;
  assign cfg_tmo_o = tmr_bus.tmo;
  assign cfg_reissue_o = tmr_bus.reissue;
  assign cfg_all_ones_o = tmr_bus.all_ones;
  assign cpl_emit_o = emit_q;
  assign cpl_merge_o = mrg_q;

endmodule

// file: testbench/rpc_ctrl_monitor.sv
`timescale 1ns/1ns
module rpc_ctrl_monitor (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Causes
  input wire logic fc_init_start_i,
  input wire logic pd_upd_req_i,
  input wire logic ph_upd_req_i,
  input wire logic nph_upd_req_i,
  input wire logic rd_first_word_i,
  input wire logic rd_last_word_i,
  input wire logic phy_retrain_i,
  input wire logic crs_cpl_i,
  // Effects
  input wire logic [4:0] pd_lines_o,
  input wire logic [7:0] pd_credit_o,
  input wire logic [5:0] nph_levels_o,
  input wire logic [7:0] nph_credit_o,
  input wire logic nph_infinite_o,
  input wire logic updatefc_p_o,
  input wire logic updatefc_np_o,
  input wire logic rd_fifo_release_o,
  input wire logic cpl_tmo_restart_o,
  input wire logic cfg_all_ones_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_no_upd;
    !pd_upd_req_i && !ph_upd_req_i;
  endsequence
  sequence s_np_req(logic inf);
    nph_upd_req_i && nph_infinite_o == inf;
  endsequence
  a_pd_credit: assert property (pd_credit_o == {1'b0, pd_lines_o, 2'b00}) else $error("pd credit");
  a_nph_credit: assert property (nph_levels_o >= 6'h08 |-> nph_credit_o == {2'b00, nph_levels_o})
    else $error("nph credit");
  a_credit_hold: assert property (!fc_init_start_i |=> $stable(pd_credit_o) && $stable(nph_credit_o))
    else $error("credit moved");
  a_upd_p_data: assert property (pd_upd_req_i |=> updatefc_p_o) else $error("no posted update");
  a_upd_p_idle: assert property (s_no_upd |=> !updatefc_p_o) else $error("stray posted update");
  a_np_finite: assert property (s_np_req(1'b0) |=> updatefc_np_o) else $error("no np update");
  a_np_inf: assert property (s_np_req(1'b1) |=> !updatefc_np_o) else $error("np update sent");
  a_rel_idle: assert property (!rd_first_word_i && !rd_last_word_i |=> !rd_fifo_release_o)
    else $error("stray release");
  a_restart_idle: assert property (!phy_retrain_i |=> !cpl_tmo_restart_o) else $error("stray restart");
  a_ones_cause: assert property (cfg_all_ones_o |-> $past(crs_cpl_i)) else $error("all ones uncaused");
endmodule
bind rpc_ctrl rpc_ctrl_monitor u_mon (.ref_clk_i, .rst_i, .fc_init_start_i, .pd_upd_req_i, .ph_upd_req_i,
  .nph_upd_req_i, .rd_first_word_i, .rd_last_word_i, .phy_retrain_i, .crs_cpl_i, .pd_lines_o, .pd_credit_o,
  .nph_levels_o, .nph_credit_o, .nph_infinite_o, .updatefc_p_o, .updatefc_np_o, .rd_fifo_release_o,
  .cpl_tmo_restart_o, .cfg_all_ones_o);

// file: testbench/rpc_ep_model.sv
`timescale 1ns/1ns
module rpc_ep_model #(
  parameter int LAT = 2
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Requests and answer mode
  input wire logic req_i,
  input wire logic silent_i,
  input wire logic crs_i,
  // Completions
  output logic cpl_o,
  output logic crs_o
);
  int cnt;
  logic crs_q;
  // The answer kind is fixed when the request arrives, so a late mode change cannot split one answer.
  always @(posedge ref_clk_i) begin
    cpl_o <= !rst_i && cnt == 1 && !crs_q;
    crs_o <= !rst_i && cnt == 1 && crs_q;
    if (rst_i) begin
      cnt <= 0;
    end else if (req_i && !silent_i) begin
      cnt <= LAT;
      crs_q <= crs_i;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// file: testbench/rpc_ctrl_tb_top.sv
`timescale 1ns/1ns
module rpc_ctrl_tb_top;
  typedef struct packed {logic [11:0] a; logic [7:0] w; logic [7:0] e;} rpc_row_t;
  localparam int FC = 0, PD = 1, PH = 2, NP = 3, FW = 4, LW = 5, RT = 6, RDY = 7, ST = 8;
  localparam int LAT = 2;
  localparam int STEP = 20;
  logic ref_clk_i, rst_i, cfg_wr_i, cfg_rd_i, up_wr_pending_i, policy, silent, crs_mode;
  logic [8:0] p;
  logic [11:0] cfg_addr_i;
  logic [7:0] cfg_wdata_i, cfg_rdata_o, pd_credit_o, ph_credit_o, nph_credit_o, d;
  logic [4:0] pd_lines_o;
  logic [5:0] ph_levels_o, nph_levels_o, hdr_cnt;
  logic nph_infinite_o, updatefc_p_o, updatefc_np_o, rd_fifo_release_o, dn_rd_hold_o, up_wr_bypass_o;
  logic slow_rd_timing_o, cpl_tmo_restart_o, cfg_cpl_i, crs_cpl_i, cfg_tmo_o, cfg_reissue_o, cfg_all_ones_o;
  logic cpl_emit_o, cpl_merge_o;
  int fails, comparisons, n, lv;
  int dly[4] = '{1, 4, 8, 16};
  rpc_row_t rows[8];

  rpc_ctrl #(.WIDE_PORT(1'b1), .CFG_TMO0_CYC(STEP), .CFG_TMO1_CYC(2 * STEP), .CFG_TMO2_CYC(3 * STEP),
    .CFG_TMO3_CYC(4 * STEP)) dut (.ref_clk_i, .rst_i, .cfg_wr_i, .cfg_rd_i, .cfg_addr_i, .cfg_wdata_i,
    .cfg_rdata_o, .fc_init_start_i(p[FC]), .pd_lines_o, .pd_credit_o, .ph_levels_o, .ph_credit_o,
    .nph_levels_o, .nph_credit_o, .nph_infinite_o, .pd_upd_req_i(p[PD]), .ph_upd_req_i(p[PH]),
    .nph_upd_req_i(p[NP]), .updatefc_p_o, .updatefc_np_o, .rd_first_word_i(p[FW]), .rd_last_word_i(p[LW]),
    .up_wr_pending_i, .rd_fifo_release_o, .dn_rd_hold_o, .up_wr_bypass_o, .slow_rd_timing_o,
    .phy_retrain_i(p[RT]), .cpl_tmo_restart_o, .cfg_req_start_i(p[ST]), .cfg_cpl_i, .crs_cpl_i,
    .separate_retry_policy_bit_i(policy), .cfg_tmo_o, .cfg_reissue_o, .cfg_all_ones_o,
    .retry_hdr_cnt_i(hdr_cnt), .port_to_core_cpl_ready_i(p[RDY]), .cpl_emit_o, .cpl_merge_o);
  rpc_ep_model #(.LAT(LAT)) ep (.ref_clk_i, .rst_i, .req_i(p[ST] | cfg_reissue_o), .silent_i(silent),
    .crs_i(crs_mode), .cpl_o(cfg_cpl_i), .crs_o(crs_cpl_i));

  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chkn(input int g, input int e);
    comparisons++;
    if (g != e) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    cfg_wr_i <= 1'b1;
    cfg_addr_i <= a;
    cfg_wdata_i <= v;
    @(posedge ref_clk_i);
    cfg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge ref_clk_i);
    cfg_rd_i <= 1'b1;
    cfg_addr_i <= a;
    @(posedge ref_clk_i);
    cfg_rd_i <= 1'b0;
    @(posedge ref_clk_i);
    #1 d = cfg_rdata_o;
  endtask
  // One-cycle request; returns just after the edge where a registered answer shows.
  task automatic pul(input int w);
    @(posedge ref_clk_i);
    p[w] <= 1'b1;
    @(posedge ref_clk_i);
    p[w] <= 1'b0;
    #1;
  endtask
  // Issues a configuration request and counts edges until the chosen pulse appears.
  task automatic req_cnt(input int w);
    @(posedge ref_clk_i);
    p[ST] <= 1'b1;
    @(posedge ref_clk_i);
    p[ST] <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      #1 n++;
    end while ((w == 0 ? cfg_tmo_o : w == 1 ? cfg_reissue_o : cfg_all_ones_o) !== 1'b1 && n < 300);
  endtask
  task automatic final_report;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    fails++;
    final_report();
  end

  initial begin
    rows = '{'{12'h1a5, 8'h3c, 8'h3c}, '{12'h1a6, 8'ha5, 8'ha5}, '{12'h1a7, 8'hff, 8'hfd},
      '{12'h1a8, 8'hb3, 8'hb3}, '{12'h1a9, 8'h01, 8'h01}, '{12'h1aa, 8'hff, 8'h1f},
      '{12'h1ab, 8'h55, 8'h00}, '{12'h1a4, 8'h77, 8'h00}};
    {rst_i, cfg_wr_i, cfg_rd_i, up_wr_pending_i, policy, silent, crs_mode} = 7'b1000110;
    {p, cfg_addr_i, cfg_wdata_i, hdr_cnt} = '0;
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      chk(d, rows[i].e);
    end
    // ****************************************
    // Reset values and credits
    // ****************************************
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    @(posedge ref_clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(12'(rpc_pkg::OFS_POSTED + i));
      chk(d, i == 0 ? rpc_pkg::RST_POSTED_WIDE : i == 1 ? rpc_pkg::RST_NPOSTED_WIDE : i == 2 ?
        rpc_pkg::RST_PERF_ONE : i == 3 ? rpc_pkg::RST_CPL_TMO : i == 4 ? rpc_pkg::RST_CRS : 8'h16);
    end
    chk(8'(up_wr_bypass_o), 8'h01);
    for (int i = 0; i < 16; i++) begin
      wr(rpc_pkg::OFS_POSTED, {i[3:0], i[3:0]});
      wr(rpc_pkg::OFS_NPOSTED, {i[0], 3'b001, i[3:0]});
      chk(pd_credit_o, 8'(4 * i));
      pul(FC);
      lv = (i < 3) ? (1 << i) : 2 * (i + 1);
      chk(8'(pd_lines_o), 8'(i + 1));
      chk(pd_credit_o, 8'(4 * (i + 1)));
      chk({ph_credit_o, 2'b00, ph_levels_o}, {8'(2 * (i + 1)), 8'(lv)});
      chk({nph_credit_o, 2'b00, nph_levels_o}, {8'(2 * (i + 1)), 8'(lv)});
      pul(NP);
      chk({updatefc_np_o, nph_infinite_o}, {!i[0], i[0]});
    end
    // ****************************************
    // Updates, ordering and read path
    // ****************************************
    pul(PH);
    chk(8'(updatefc_p_o), 8'h01);
    wr(rpc_pkg::OFS_PERF_TWO, 8'h07);
    pul(PH);
    chk({updatefc_p_o, slow_rd_timing_o}, 8'h01);
    pul(PD);
    chk(8'(updatefc_p_o), 8'h01);
    wr(rpc_pkg::OFS_PERF_ONE, 8'h1c);
    up_wr_pending_i <= 1'b1;
    pul(FW);
    chk({rd_fifo_release_o, dn_rd_hold_o, up_wr_bypass_o}, 8'h07);
    pul(LW);
    chk(8'(rd_fifo_release_o), 8'h00);
    wr(rpc_pkg::OFS_PERF_ONE, 8'hc0);
    pul(FW);
    chk({rd_fifo_release_o, dn_rd_hold_o, up_wr_bypass_o}, 8'h00);
    pul(LW);
    chk(8'(rd_fifo_release_o), 8'h01);
    pul(RT);
    chk(8'(cpl_tmo_restart_o), 8'h00);
    wr(rpc_pkg::OFS_CPL_TMO, 8'h90);
    pul(RT);
    chk(8'(cpl_tmo_restart_o), 8'h01);
    // ****************************************
    // Configuration timer and retry status
    // ****************************************
    for (int k = 0; k < 4; k++) begin
      wr(rpc_pkg::OFS_CPL_TMO, 8'(k << 4));
      req_cnt(0);
      chkn(n, STEP * (k + 1));
    end
    silent = 1'b0;
    wr(rpc_pkg::OFS_CRS, 8'h01);
    for (int k = 0; k < 4; k++) begin
      wr(rpc_pkg::OFS_CPL_TMO, 8'(8'h30 | k));
      crs_mode = 1'b1;
      req_cnt(1);
      crs_mode = 1'b0;
      chkn(n, LAT + dly[k]);
      repeat (8) @(posedge ref_clk_i);
    end
    crs_mode = 1'b1;
    policy <= 1'b0;
    req_cnt(2);
    chkn(n, LAT + 1);
    wr(rpc_pkg::OFS_CRS, 8'h00);
    policy <= 1'b1;
    req_cnt(2);
    chkn(n, LAT + 1);
    // ****************************************
    // Completion merging
    // ****************************************
    wr(rpc_pkg::OFS_PERF_TWO, 8'h06);
    hdr_cnt <= 6'h01;
    pul(RDY);
    chk({cpl_merge_o, cpl_emit_o}, 8'h01);
    hdr_cnt <= 6'h02;
    pul(RDY);
    chk({cpl_merge_o, cpl_emit_o}, 8'h00);
    pul(RDY);
    chk({cpl_merge_o, cpl_emit_o}, 8'h02);
    wr(rpc_pkg::OFS_PERF_TWO, 8'h0c);
    pul(RDY);
    chk({cpl_merge_o, cpl_emit_o}, 8'h01);
    wr(rpc_pkg::OFS_PERF_TWO, 8'h0e);
    hdr_cnt <= 6'h03;
    pul(RDY);
    chk({cpl_merge_o, cpl_emit_o}, 8'h01);
    hdr_cnt <= 6'h04;
    pul(RDY);
    pul(RDY);
    chk({cpl_merge_o, cpl_emit_o}, 8'h02);
    final_report();
  end
endmodule
